// ===== core/vdsr_regs.sv
// Status, error, counter and curve-bank registers of the denoiser
`timescale 1ns/10ps
`default_nettype none
`include "vdsr_defines.svh"

module vdsr_regs
    import vdsr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        cur_tvalid,
    input  wire logic        cur_tready,
    input  wire logic        cur_tuser,
    input  wire logic        cur_tlast,
    input  wire logic        old_tvalid,
    input  wire logic        old_tready,
    input  wire logic        old_tuser,
    input  wire logic        old_tlast,
    input  wire logic        curve_rd_en,
    input  wire logic [7:0]  curve_rd_addr,
    output vdsr_coef_t       curve_coef,
    output logic             curve_zero,
    output vdsr_bank_t       active_bank,
    output vdsr_dim_t        active_width,
    output vdsr_dim_t        active_height,
    output logic             core_enable,
    output logic             filter_bypass,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [2:0]  control_r;
    logic [2:0]  status_r;
    vdsr_err_t   stream_error_flags_r;
    logic [2:0]  interrupt_mask_r;
    logic [31:0] frames_done_counter_r;
    logic [31:0] lines_done_counter_r;
    logic [31:0] pixels_done_counter_r;
    vdsr_dim_t   shadow_width_r;
    vdsr_dim_t   shadow_height_r;
    vdsr_bank_t  shadow_bank_r;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire logic wr_control = reg_wr_en && (reg_addr == `VDSR_OFS_CONTROL);
    wire logic wr_status  = reg_wr_en && (reg_addr == `VDSR_OFS_STATUS);
    wire logic wr_error   = reg_wr_en && (reg_addr == `VDSR_OFS_ERROR);
    wire logic wr_mask    = reg_wr_en && (reg_addr == `VDSR_OFS_IRQ_MASK);
    wire logic wr_dims    = reg_wr_en && (reg_addr == `VDSR_OFS_DIMS);
    wire logic wr_load    = reg_wr_en && (reg_addr == `VDSR_OFS_CURVE_LOAD);
    wire logic wr_bank    = reg_wr_en && (reg_addr == `VDSR_OFS_BANK_SEL);

    // Curve-load field split
    wire vdsr_coef_t ld_data = reg_wdata[`VDSR_LD_DATA_LSB +: 8];
    wire logic [6:0] ld_index = reg_wdata[`VDSR_LD_INDEX_LSB +: 7];
    wire logic       ld_chroma = reg_wdata[`VDSR_LD_HALF_BIT];
    wire vdsr_bank_t ld_bank = reg_wdata[`VDSR_LD_BANK_LSB +: 4];

    // ------------------------------------------------------------------
    // Stream framing checks, one per input stream
    // ------------------------------------------------------------------
    // Same clock as the core, so no synchronisers on the stream taps
    wire logic [1:0] s_beat = {old_tvalid & old_tready,
                               cur_tvalid & cur_tready};
    wire logic [1:0] s_sof  = {old_tuser, cur_tuser};
    wire logic [1:0] s_eol  = {old_tlast, cur_tlast};
    wire vdsr_cnt_t  exp_w  = {1'b0, active_width};
    wire vdsr_cnt_t  exp_h  = {1'b0, active_height};

    vdsr_cnt_t  pix_r     [2];
    vdsr_cnt_t  line_r    [2];
    logic [1:0] seen_sof_r;
    vdsr_err_t  err_set;

    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_stream
            wire vdsr_cnt_t pix_inc  = pix_r[s] + 14'h0001;
            wire vdsr_cnt_t line_inc = line_r[s] + 14'h0001;
            wire vdsr_cnt_t pix_nxt  = s_eol[s] ? 14'h0000 :
                                       (s_sof[s] ? 14'h0001 : pix_inc);
            wire vdsr_cnt_t line_nxt = s_sof[s] ?
                                       (s_eol[s] ? 14'h0001 : 14'h0000) :
                                       (s_eol[s] ? line_inc : line_r[s]);

            // Line end before the programmed width
            assign err_set[4*s+0] = s_beat[s] && s_eol[s] &&
                                    (pix_inc < exp_w);
            // Programmed width reached with no line end
            assign err_set[4*s+1] = s_beat[s] && !s_eol[s] &&
                                    (pix_inc == exp_w);
            // Frame start before all programmed lines arrived
            assign err_set[4*s+2] = s_beat[s] && s_sof[s] && seen_sof_r[s]
                                    && (line_r[s] < exp_h);
            // All lines done but the next beat is not a frame start
            assign err_set[4*s+3] = s_beat[s] && !s_sof[s] &&
                                    seen_sof_r[s] && (pix_r[s] == 14'h0000)
                                    && (line_r[s] == exp_h);

            // Position within the line and frame
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    pix_r[s]      <= 14'h0000;
                    line_r[s]     <= 14'h0000;
                    seen_sof_r[s] <= 1'b0;
                end else if (s_beat[s]) begin
                    pix_r[s]  <= pix_nxt;
                    line_r[s] <= line_nxt;
                    if (s_sof[s]) begin
                        seen_sof_r[s] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Size limits fixed at build time, judged on the current stream
    wire vdsr_cnt_t cur_pix_inc  = pix_r[0] + 14'h0001;
    wire vdsr_cnt_t cur_line_inc = line_r[0] + 14'h0001;
    assign err_set[`VDSR_ERR_WIDTH_OVF] = s_beat[0] &&
        (cur_pix_inc == `VDSR_MAX_WIDTH + 14'h0001);
    assign err_set[`VDSR_ERR_HEIGHT_OVF] = s_beat[0] && s_eol[0] &&
        !s_sof[0] &&
        (cur_line_inc == `VDSR_MAX_HEIGHT + 14'h0001);

    // ------------------------------------------------------------------
    // Frame events on the current stream
    // ------------------------------------------------------------------
    wire logic cur_frame_start = s_beat[0] && s_sof[0];
    wire logic cur_line_end    = s_beat[0] && s_eol[0];
    wire logic cur_frame_done  = cur_line_end && !s_sof[0] &&
                                 (cur_line_inc == exp_h);
    wire logic commit_now = cur_frame_start &&
                            control_r[`VDSR_CTRL_COMMIT];

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------
    // Only newly rising bits count, so a held error does not re-arm
    wire vdsr_err_t err_rise = err_set & ~stream_error_flags_r;
    wire vdsr_err_t err_clr  = wr_error ? reg_wdata[9:0] : 10'h000;
    // Set wins over a clear landing in the same cycle
    wire vdsr_err_t err_nxt  = (stream_error_flags_r & ~err_clr)
                               | err_set;
    wire logic any_err_left  = |err_nxt;

    wire logic [2:0] st_set = {|err_rise, cur_frame_done,
                               cur_frame_start};
    // Error summary cannot be cleared while an error bit still stands,
    // so the interrupt holds until the error source itself is cleared
    wire logic [2:0] st_clr = wr_status ?
        (reg_wdata[2:0] & {~any_err_left, 2'b11}) : 3'h0;
    wire logic [2:0] st_nxt = (status_r & ~st_clr) | st_set;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            stream_error_flags_r <= 10'h000;
            status_r             <= 3'h0;
        end else begin
            stream_error_flags_r <= err_nxt;
            status_r             <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Control, mask and processor-side copies
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            control_r        <= 3'h0;
            interrupt_mask_r <= 3'h0;
            shadow_width_r   <= `VDSR_DEF_WIDTH;
            shadow_height_r  <= `VDSR_DEF_HEIGHT;
            shadow_bank_r    <= `VDSR_DEF_BANK;
        end else begin
            if (wr_control) begin
                control_r <= reg_wdata[2:0];
            end
            if (wr_mask) begin
                interrupt_mask_r <= reg_wdata[2:0];
            end
            if (wr_dims) begin
                shadow_width_r  <= reg_wdata[`VDSR_DIM_W_LSB +: 13];
                shadow_height_r <= reg_wdata[`VDSR_DIM_H_LSB +: 13];
            end
            if (wr_bank) begin
                shadow_bank_r <= reg_wdata[3:0];
            end
        end
    end

    // Working copies move only at a committed frame start
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            active_width  <= `VDSR_DEF_WIDTH;
            active_height <= `VDSR_DEF_HEIGHT;
            active_bank   <= `VDSR_DEF_BANK;
        end else if (commit_now) begin
            active_width  <= shadow_width_r;
            active_height <= shadow_height_r;
            active_bank   <= shadow_bank_r;
        end
    end

    // Control bits and the masked interrupt summary mirrored as flops
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            core_enable   <= 1'b0;
            filter_bypass <= 1'b0;
            irq           <= 1'b0;
        end else begin
            core_enable   <= control_r[`VDSR_CTRL_ENABLE];
            filter_bypass <= control_r[`VDSR_CTRL_BYPASS];
            irq           <= |(st_nxt & interrupt_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Throughput counters
    // ------------------------------------------------------------------
    // Free-running wrap at 2^32; software takes differences
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            frames_done_counter_r <= 32'h00000000;
            lines_done_counter_r  <= 32'h00000000;
            pixels_done_counter_r <= 32'h00000000;
        end else begin
            if (cur_frame_start) begin
                frames_done_counter_r <= frames_done_counter_r + 32'h1;
            end
            if (cur_line_end) begin
                lines_done_counter_r <= lines_done_counter_r + 32'h1;
            end
            if (s_beat[0]) begin
                pixels_done_counter_r <= pixels_done_counter_r + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Curve store
    // ------------------------------------------------------------------
    vdsr_curve_mem u_curve (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .wr_en   (wr_load),
        .wr_bank (ld_bank),
        .wr_addr ({ld_chroma, ld_index}),
        .wr_data (ld_data),
        .rd_en   (curve_rd_en),
        .rd_bank (active_bank),
        .rd_addr (curve_rd_addr),
        .rd_data (curve_coef),
        .rd_zero (curve_zero)
    );

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Load register is write-only; unmapped offsets read zero
    wire logic [31:0] rd_mux =
        (reg_addr == `VDSR_OFS_CONTROL)  ? {29'h0, control_r} :
        (reg_addr == `VDSR_OFS_STATUS)   ? {29'h0, status_r} :
        (reg_addr == `VDSR_OFS_ERROR)    ? {22'h0, stream_error_flags_r} :
        (reg_addr == `VDSR_OFS_IRQ_MASK) ? {29'h0, interrupt_mask_r} :
        (reg_addr == `VDSR_OFS_REVISION) ? `VDSR_REVISION :
        (reg_addr == `VDSR_OFS_FRAMES)   ? frames_done_counter_r :
        (reg_addr == `VDSR_OFS_LINES)    ? lines_done_counter_r :
        (reg_addr == `VDSR_OFS_PIXELS)   ? pixels_done_counter_r :
        (reg_addr == `VDSR_OFS_DIMS)     ?
            {3'h0, shadow_height_r, 3'h0, shadow_width_r} :
        (reg_addr == `VDSR_OFS_BANK_SEL) ? {28'h0, shadow_bank_r} :
        32'h00000000;

    // One cycle read latency
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata  <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rd_mux;
            end
        end
    end

endmodule
`default_nettype wire

// ===== core/vdsr_defines.svh
// Register map, field positions and reset values of the status block
`ifndef VDSR_DEFINES_SVH
`define VDSR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define VDSR_OFS_CONTROL    12'h000
`define VDSR_OFS_STATUS     12'h004
`define VDSR_OFS_ERROR      12'h008
`define VDSR_OFS_IRQ_MASK   12'h00c
`define VDSR_OFS_REVISION   12'h010
`define VDSR_OFS_FRAMES     12'h014
`define VDSR_OFS_LINES      12'h018
`define VDSR_OFS_PIXELS     12'h01c
`define VDSR_OFS_DIMS       12'h020
`define VDSR_OFS_CURVE_LOAD 12'h100
`define VDSR_OFS_BANK_SEL   12'h104

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VDSR_CTRL_ENABLE    0
`define VDSR_CTRL_COMMIT    1
`define VDSR_CTRL_BYPASS    2
`define VDSR_ST_STARTED     0
`define VDSR_ST_COMPLETE    1
`define VDSR_ST_STREAM_ERR  2
`define VDSR_ERR_WIDTH_OVF  8
`define VDSR_ERR_HEIGHT_OVF 9
`define VDSR_DIM_W_LSB      0
`define VDSR_DIM_H_LSB      16
`define VDSR_LD_DATA_LSB    0
`define VDSR_LD_INDEX_LSB   16
`define VDSR_LD_HALF_BIT    23
`define VDSR_LD_BANK_LSB    24

// ----------------------------------------------------------------------
// Reset values and build-time sizes
// ----------------------------------------------------------------------
`define VDSR_REVISION       32'h01000000
`define VDSR_DEF_WIDTH      13'h0780
`define VDSR_DEF_HEIGHT     13'h0438
`define VDSR_MAX_WIDTH      14'h0780
`define VDSR_MAX_HEIGHT     14'h0438
`define VDSR_DEF_BANK       4'h0
`define VDSR_PRESET_BANKS   8
`define VDSR_BANKS          16
`define VDSR_BANK_WORDS     256

`endif

// ===== core/vdsr_pkg.sv
// Types shared by the status block and its curve store
package vdsr_pkg;
    typedef logic [12:0] vdsr_dim_t;
    typedef logic [13:0] vdsr_cnt_t;
    typedef logic [7:0]  vdsr_coef_t;
    typedef logic [3:0]  vdsr_bank_t;
    typedef logic [9:0]  vdsr_err_t;
endpackage

// ===== core/vdsr_curve_mem.sv
// Filter-curve store: 16 banks of 256 coefficients, one write, one read
`timescale 1ns/10ps
`default_nettype none
`include "vdsr_defines.svh"

module vdsr_curve_mem
    import vdsr_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       wr_en,
    input  wire vdsr_bank_t wr_bank,
    input  wire logic [7:0] wr_addr,
    input  wire vdsr_coef_t wr_data,
    input  wire logic       rd_en,
    input  wire vdsr_bank_t rd_bank,
    input  wire logic [7:0] rd_addr,
    output vdsr_coef_t      rd_data,
    output logic            rd_zero
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    vdsr_coef_t curve_mem [0:`VDSR_BANKS*`VDSR_BANK_WORDS-1];

    // Banks 0..7 preset, strong filtering in 0 down to light in 7
    initial begin : preset
        int b;
        int i;
        int v;
        for (b = 0; b < `VDSR_BANKS; b++) begin
            for (i = 0; i < `VDSR_BANK_WORDS; i++) begin
                v = (255 - 2 * (i % 128)) >> b;
                if (b >= `VDSR_PRESET_BANKS) begin
                    v = 0;
                end
                curve_mem[b * `VDSR_BANK_WORDS + i] = v[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------
    // One coefficient per write, others untouched
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            curve_mem[{wr_bank, wr_addr}] <= wr_data;
        end
    end

    // Registered read; zero means pass the current pixel unfiltered
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rd_data <= 8'h00;
            rd_zero <= 1'b1;
        end else if (rd_en) begin
            rd_data <= curve_mem[{rd_bank, rd_addr}];
            rd_zero <= (curve_mem[{rd_bank, rd_addr}] == 8'h00);
        end
    end

endmodule
`default_nettype wire

// ===== verification/vdsr_regs_properties.sv
// Port-level checks of the status and curve register block
`timescale 1ns/10ps
`default_nettype none
`include "vdsr_defines.svh"

module vdsr_regs_properties
    import vdsr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid,
    input  wire logic        cur_tvalid,
    input  wire logic        cur_tready,
    input  wire logic        cur_tuser,
    input  wire logic        old_tvalid,
    input  wire logic        old_tready,
    input  wire logic        curve_rd_en,
    input  wire vdsr_coef_t  curve_coef,
    input  wire logic        curve_zero,
    input  wire vdsr_bank_t  active_bank,
    input  wire vdsr_dim_t   active_width,
    input  wire vdsr_dim_t   active_height,
    input  wire logic        irq
);
    // Stream beats and bus writes are the only causes of a rising irq
    wire beat = (cur_tvalid && cur_tready) || (old_tvalid && old_tready);
    wire ev   = beat || reg_wr_en;
    wire sof  = cur_tvalid && cur_tready && cur_tuser;

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    rvalid_follows_a:
        assert property (reg_rd_en |=> reg_rvalid)
        else $error("read strobe not answered");
    revision_value_a:
        assert property (reg_rd_en && reg_addr == `VDSR_OFS_REVISION
            |=> reg_rdata == `VDSR_REVISION)
        else $error("revision read wrong");
    irq_fall_a:
        assert property ($fell(irq) |-> $past(reg_wr_en))
        else $error("irq dropped without a write");
    irq_rise_a:
        assert property ($rose(irq) |-> $past(ev) || $past(ev, 2))
        else $error("irq rose without cause");
    commit_edge_a:
        assert property (!$stable({active_bank, active_width,
            active_height}) |-> $past(sof))
        else $error("working copy changed off frame start");
    coef_zero_a:
        assert property (curve_rd_en |=> curve_zero == (curve_coef == 8'h00))
        else $error("zero flag disagrees with coefficient");
    dims_fields_a:
        assert property (reg_wr_en && reg_addr == `VDSR_OFS_DIMS ##2
            reg_rd_en && reg_addr == `VDSR_OFS_DIMS
            |=> reg_rdata == ($past(reg_wdata, 3) & 32'h1fff1fff))
        else $error("dimension fields misplaced");
    err_clear_a:
        assert property (reg_wr_en && reg_addr == `VDSR_OFS_ERROR && !beat
            ##1 !beat ##1 reg_rd_en && reg_addr == `VDSR_OFS_ERROR && !beat
            |=> (reg_rdata & $past(reg_wdata, 3)) == 32'h0)
        else $error("error bit not cleared by one");
endmodule

bind vdsr_regs vdsr_regs_properties chk (
    .ref_clk(ref_clk), .rstn(rstn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cur_tvalid(cur_tvalid), .cur_tready(cur_tready),
    .cur_tuser(cur_tuser), .old_tvalid(old_tvalid),
    .old_tready(old_tready), .curve_rd_en(curve_rd_en),
    .curve_coef(curve_coef), .curve_zero(curve_zero),
    .active_bank(active_bank), .active_width(active_width),
    .active_height(active_height), .irq(irq));
`default_nettype wire

// ===== verification/vdsr_host.sv
// Host processor model on the plain strobe register bus
`timescale 1ns/10ps
`default_nettype none

module vdsr_host (
    input  wire logic        ref_clk,
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    output logic [11:0]      reg_addr,
    output logic [31:0]      reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    // Idle bus at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 12'hfff;
        reg_wdata = 32'h0;
    end

    // One write; released lines show inverted junk, not the old value.
    // One idle edge follows so the next call never reassigns the address
    // in the same time step.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        @(posedge ref_clk);
    endtask

    // One read; gives up after eight edges and hands back unknowns
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int n;
        d = 'x;
        n = 0;
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        while (reg_rvalid !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            n++;
        end
        if (reg_rvalid === 1'b1) d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== verification/vdsr_regs_tb.sv
// Self-checking bench of the status and curve register block
`timescale 1ns/10ps
`default_nettype none
`include "vdsr_defines.svh"

module vdsr_regs_tb
    import vdsr_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr_en, reg_rd_en, reg_rvalid, irq;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [1:0]  tv = 2'b00, tr = 2'b11, tu = 2'b11, tl = 2'b11;
    logic        curve_rd_en = 1'b0, curve_zero;
    logic [7:0]  curve_rd_addr = 8'h00;
    vdsr_coef_t  curve_coef;
    vdsr_bank_t  active_bank;
    vdsr_dim_t   active_width, active_height;
    int          fails = 0, samples_checked = 0, nf = 0, nl = 0, np = 0;

    always #20 ref_clk = ~ref_clk;

    vdsr_regs uut (.ref_clk(ref_clk), .rstn(rstn), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .cur_tvalid(tv[0]), .cur_tready(tr[0]), .cur_tuser(tu[0]),
        .cur_tlast(tl[0]), .old_tvalid(tv[1]), .old_tready(tr[1]),
        .old_tuser(tu[1]), .old_tlast(tl[1]), .curve_rd_en(curve_rd_en),
        .curve_rd_addr(curve_rd_addr), .curve_coef(curve_coef),
        .curve_zero(curve_zero), .active_bank(active_bank),
        .active_width(active_width), .active_height(active_height),
        .core_enable(), .filter_bypass(), .irq(irq));
    vdsr_host host (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic end_sim;
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        host.rd(a, d);
        chk(d, e);
    endtask
    // Level outputs are judged two edges on, once the update has landed
    task automatic irq_is(input logic e);
        repeat (2) @(posedge ref_clk);
        chk(irq, e);
    endtask
    // Back-to-back beats; idle side-band held high to catch misuse
    task automatic line(input int s, input int n, input bit u, input bit l);
        if (s == 0) begin
            np += n;
            nf += u;
            nl += l;
        end
        for (int i = 0; i < n; i++) begin
            tv[s] <= 1'b1;
            tu[s] <= u && i == 0;
            tl[s] <= l && i == n - 1;
            @(posedge ref_clk);
        end
        tv[s] <= 1'b0;
        tu[s] <= 1'b1;
        tl[s] <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic curve_rd(input logic [7:0] a, input vdsr_coef_t e);
        curve_rd_en   <= 1'b1;
        curve_rd_addr <= a;
        @(posedge ref_clk);
        curve_rd_en   <= 1'b0;
        curve_rd_addr <= ~a;
        @(posedge ref_clk);
        chk(curve_coef, e);
        chk(curve_zero, e == 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rdc(`VDSR_OFS_REVISION, `VDSR_REVISION);
        host.wr(`VDSR_OFS_REVISION, 32'h0);
        rdc(`VDSR_OFS_REVISION, `VDSR_REVISION);
        rdc(12'h030, 32'h0);
        rdc(`VDSR_OFS_PIXELS, 32'h0);
        curve_rd(8'h00, 8'hff);
        curve_rd(8'h81, 8'hfd);
    endtask
    // Load a spare bank, then switch to it at a frame start
    task automatic t_commit;
        host.wr(`VDSR_OFS_CURVE_LOAD, 32'h0885003c);
        host.wr(`VDSR_OFS_CURVE_LOAD, 32'h08050011);
        host.wr(`VDSR_OFS_DIMS, 32'he020e020);
        rdc(`VDSR_OFS_DIMS, 32'h00200020);
        host.wr(`VDSR_OFS_BANK_SEL, 32'h8);
        rdc(`VDSR_OFS_BANK_SEL, 32'h8);
        chk(active_width, `VDSR_DEF_WIDTH);
        host.wr(`VDSR_OFS_CONTROL, 32'h3);
        line(0, 1, 1, 0);
        chk({active_height, active_width}, {13'd32, 13'd32});
        chk(active_bank, 4'h8);
        curve_rd(8'h85, 8'h3c);
        curve_rd(8'h05, 8'h11);
        curve_rd(8'h84, 8'h00);
    endtask
    task automatic t_errors;
        host.wr(`VDSR_OFS_IRQ_MASK, 32'h4);
        irq_is(1'b0);
        line(0, 9, 0, 1);
        irq_is(1'b1);
        rdc(`VDSR_OFS_STATUS, 32'h5);
        host.wr(`VDSR_OFS_ERROR, 32'h0);
        rdc(`VDSR_OFS_ERROR, 32'h1);
        host.wr(`VDSR_OFS_STATUS, 32'h4);
        irq_is(1'b1);
        line(0, 32, 0, 0);
        rdc(`VDSR_OFS_ERROR, 32'h3);
        host.wr(`VDSR_OFS_ERROR, 32'h3);
        host.wr(`VDSR_OFS_STATUS, 32'h4);
        irq_is(1'b0);
        host.wr(`VDSR_OFS_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        host.wr(`VDSR_OFS_STATUS, 32'h1);
        irq_is(1'b0);
        line(0, 1, 1, 0);
        rdc(`VDSR_OFS_ERROR, 32'h4);
        line(1, 1, 1, 0);
        line(1, 9, 0, 1);
        line(1, 1, 1, 0);
        rdc(`VDSR_OFS_ERROR, 32'h54);
        host.wr(`VDSR_OFS_ERROR, 32'h3ff);
        rdc(`VDSR_OFS_ERROR, 32'h0);
        line(0, 12'h781, 0, 0);
        host.rd(`VDSR_OFS_ERROR, d);
        chk(d & 32'h100, 32'h100);
        rdc(`VDSR_OFS_FRAMES, nf);
        rdc(`VDSR_OFS_LINES, nl);
        rdc(`VDSR_OFS_PIXELS, np);
        // Mid-run reset must bring the pixel and frame counters back to zero
        rstn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rdc(`VDSR_OFS_PIXELS, 32'h0);
        rdc(`VDSR_OFS_FRAMES, 32'h0);
    endtask

    // Main sequence: five cycles of reset, then the scenarios
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_commit();
        t_errors();
        end_sim();
    end
    // Watchdog well beyond the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
